// [rtl/pmc_pkg.sv]
// constants, field layout and decode helpers for the periodic modulo counter
package pmc_pkg;

	// register bus geometry
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [1:0] OFS_CONTROL_STATUS = 2'h0;
	localparam logic [1:0] OFS_CURRENT_COUNT = 2'h1;
	localparam logic [1:0] OFS_MATCH_LIMIT = 2'h2;

	// control_status field positions
	localparam int FLAG_BIT = 7;
	localparam int SEL_HI = 6;
	localparam int SEL_LO = 5;
	localparam int IE_BIT = 4;
	localparam int DIV_HI = 3;
	localparam int DIV_LO = 0;

	// reset values
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic [3:0] DIV_RESET = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// prescaler width, wide enough for the largest divide of 200000
	localparam int PRE_W = 18;
	localparam logic [PRE_W-1:0] PRE_ZERO = 18'h00000;
	localparam logic [PRE_W-1:0] PRE_ONE = 18'h00001;

	// clock source codes
	typedef enum logic [1:0] {
		PMC_SRC_LPO = 2'b00,
		PMC_SRC_EXT = 2'b01,
		PMC_SRC_INT = 2'b10,
		PMC_SRC_INT2 = 2'b11
	} pmc_src_t;

	// index of each source in the synchroniser vector
	localparam int IDX_LPO = 0;
	localparam int IDX_EXT = 1;
	localparam int IDX_INT = 2;
	localparam int NUM_SRC = 3;

	// divide ratio for a divider code; zero means the prescaler is off
	function automatic logic [PRE_W-1:0] pmc_divide(input logic [3:0] code,
			input logic sel_low);
		logic [PRE_W-1:0] r;
		r = PRE_ZERO;
		if (!sel_low) begin
			unique case (code)
				4'h0: r = 18'h00000;
				4'h1: r = 18'h00008;
				4'h2: r = 18'h00020;
				4'h3: r = 18'h00040;
				4'h4: r = 18'h00080;
				4'h5: r = 18'h00100;
				4'h6: r = 18'h00200;
				4'h7: r = 18'h00400;
				4'h8: r = 18'h00001;
				4'h9: r = 18'h00002;
				4'hA: r = 18'h00004;
				4'hB: r = 18'h0000A;
				4'hC: r = 18'h00010;
				4'hD: r = 18'h00064;
				4'hE: r = 18'h001F4;
				4'hF: r = 18'h003E8;
			endcase
		end else begin
			unique case (code)
				4'h0: r = 18'h00000;
				4'h1: r = 18'h00400;
				4'h2: r = 18'h00800;
				4'h3: r = 18'h01000;
				4'h4: r = 18'h02000;
				4'h5: r = 18'h04000;
				4'h6: r = 18'h08000;
				4'h7: r = 18'h10000;
				4'h8: r = 18'h003E8;
				4'h9: r = 18'h007D0;
				4'hA: r = 18'h01388;
				4'hB: r = 18'h02710;
				4'hC: r = 18'h04E20;
				4'hD: r = 18'h0C350;
				4'hE: r = 18'h186A0;
				4'hF: r = 18'h30D40;
			endcase
		end
		return r;
	endfunction

endpackage

// [rtl/pmc_counter.sv]
// periodic modulo counter: clock select, prescaler, 8-bit counter, match flag
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pmc_counter
	import pmc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [DATA_W-1:0] rd_data_out,
	// raw clock sources, asynchronous to clk_in
	input wire logic low_power_osc_clock_in,
	input wire logic external_ref_clock_in,
	input wire logic internal_ref_clock_in,
	// system mode indications, same clock domain
	input wire logic deep_stop_mode_in,
	input wire logic debug_active_in,
	// interrupt request
	output logic match_irq_out
);

	////////////////////////////////////////////////////////////////////////
	// register state

	logic match_flag; // sticky match indication
	logic [1:0] source_select; // prescaler input choice
	logic match_irq_enable; // gates flag onto interrupt
	logic [3:0] divider_select; // prescaler ratio code
	logic [7:0] modulo_value; // compare limit
	logic [7:0] count_value; // main up-counter
	logic [PRE_W-1:0] presc; // prescaler count

	// decoded write strobes
	logic wr_ctrl;
	logic wr_mod;
	assign wr_ctrl = wr_in && (addr_in == OFS_CONTROL_STATUS);
	assign wr_mod = wr_in && (addr_in == OFS_MATCH_LIMIT);

	// fields of an incoming control write
	logic [1:0] wr_sel;
	logic [3:0] wr_div;
	assign wr_sel = wr_data_in[SEL_HI:SEL_LO];
	assign wr_div = wr_data_in[DIV_HI:DIV_LO];

	////////////////////////////////////////////////////////////////////////
	// clock source synchronisers

	logic [NUM_SRC-1:0] src_raw; // asynchronous source levels
	logic [NUM_SRC-1:0] src_meta; // first stage, read by second only
	logic [NUM_SRC-1:0] src_sync; // second stage, safe to use
	logic [NUM_SRC-1:0] src_prev; // delayed copy for edge detect
	assign src_raw[IDX_LPO] = low_power_osc_clock_in;
	assign src_raw[IDX_EXT] = external_ref_clock_in;
	assign src_raw[IDX_INT] = internal_ref_clock_in;

	// sources must be slower than half of clk_in for edges to survive
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : g_sync
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					src_meta[gi] <= 1'b0;
					src_sync[gi] <= 1'b0;
					src_prev[gi] <= 1'b0;
				end else begin
					src_meta[gi] <= src_raw[gi];
					src_sync[gi] <= src_meta[gi];
					src_prev[gi] <= src_sync[gi];
				end
			end
		end
	endgenerate

	// rising edges of each synchronised source
	logic [NUM_SRC-1:0] src_rise;
	assign src_rise = src_sync & ~src_prev;

	////////////////////////////////////////////////////////////////////////
	// source pick, divide ratio and run conditions

	logic sel_edge; // edge of the chosen source
	logic [PRE_W-1:0] divide; // current divide ratio
	logic src_halted; // source unavailable in deep stop
	logic running; // prescaler may advance
	logic clr; // software clear of both counters
	logic tick; // prescaler output pulse
	logic match; // count equals limit

	// 1x picks the internal reference
	always_comb begin
		unique case (source_select)
			PMC_SRC_LPO: sel_edge = src_rise[IDX_LPO];
			PMC_SRC_EXT: sel_edge = src_rise[IDX_EXT];
			default: sel_edge = src_rise[IDX_INT];
		endcase
	end

	// ratio depends on source low bit as well as the code
	assign divide = pmc_divide(divider_select, source_select[SEL_LO-SEL_LO]);

	// wait and light stop do not appear here: counting carries on
	assign src_halted = deep_stop_mode_in &&
		(source_select != PMC_SRC_LPO);
	assign running = (divide != PRE_ZERO) && !debug_active_in &&
		!src_halted;

	// any limit write clears; a control write clears only when source or divider changes value
	assign clr = wr_mod ||
		(wr_ctrl && ((wr_sel != source_select) ||
		(wr_div != divider_select)));
	// a clear in the same cycle swallows the tick
	assign tick = running && sel_edge && !clr &&
		(presc == divide - PRE_ONE);
	assign match = (count_value == modulo_value);

	////////////////////////////////////////////////////////////////////////
	// prescaler

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			presc <= PRE_ZERO;
		end else if (clr) begin
			presc <= PRE_ZERO;
		end else if (running && sel_edge) begin
			if (tick) begin
				presc <= PRE_ZERO;
			end else begin
				presc <= presc + PRE_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// main counter

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count_value <= BYTE_ZERO;
		end else if (clr) begin
			count_value <= BYTE_ZERO;
		end else if (tick) begin
			if (match) begin
				count_value <= BYTE_ZERO;
			end else begin
				count_value <= count_value + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// match flag

	// new match beats a simultaneous write-one clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			match_flag <= 1'b0;
		end else if (tick && match) begin
			match_flag <= 1'b1;
		end else if (wr_ctrl && wr_data_in[FLAG_BIT]) begin
			match_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control fields and modulo register

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			source_select <= SEL_RESET;
			match_irq_enable <= 1'b0;
			divider_select <= DIV_RESET;
		end else if (wr_ctrl) begin
			source_select <= wr_sel;
			match_irq_enable <= wr_data_in[IE_BIT];
			divider_select <= wr_div;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			modulo_value <= BYTE_ZERO;
		end else if (wr_mod) begin
			modulo_value <= wr_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt output

	// registered, so it follows the flag by one cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			match_irq_out <= 1'b0;
		end else begin
			match_irq_out <= match_flag && match_irq_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data

	// count is read-only: no write decode exists for it
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_data_out <= BYTE_ZERO;
		end else if (rd_in) begin
			unique case (addr_in)
				OFS_CONTROL_STATUS: rd_data_out <= {match_flag,
					source_select, match_irq_enable, divider_select};
				OFS_CURRENT_COUNT: rd_data_out <= count_value;
				OFS_MATCH_LIMIT: rd_data_out <= modulo_value;
				default: rd_data_out <= BYTE_ZERO;
			endcase
		end else begin
			rd_data_out <= BYTE_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	// every check lives in the one system clock domain, so a single
	// default clocking and reset gate serve them all; the source clocks
	// are only ever seen here through their synchronised edges
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// a match tick folds the count back to zero
	count_wrap_a: assert property (
		tick && match |=> count_value == BYTE_ZERO)
		else $error("counter did not wrap after match");

	// an ordinary tick moves the count up by exactly one
	count_step_a: assert property (
		tick && !match |=> count_value == $past(count_value) + 8'h01)
		else $error("counter did not step by one");

	// the flag rises on the wrap, not on reaching the limit
	flag_set_a: assert property (
		tick && match |=> match_flag)
		else $error("match flag not set on wrap");

	// a set flag stays up until software writes a one to it
	flag_hold_a: assert property (
		match_flag && !(wr_ctrl && wr_data_in[FLAG_BIT]) |=> match_flag)
		else $error("match flag dropped without a clear");

	// a zero limit flags on every prescaler tick
	zero_mod_a: assert property (
		tick && modulo_value == BYTE_ZERO |=>
		match_flag && count_value == BYTE_ZERO)
		else $error("zero limit did not flag each tick");

	// any limit write restarts both counters
	mod_clear_a: assert property (
		wr_mod |=> count_value == BYTE_ZERO && presc == PRE_ZERO)
		else $error("modulo write did not clear counters");

	// a new source restarts both counters
	sel_clear_a: assert property (
		wr_ctrl && wr_sel != source_select |=>
		count_value == BYTE_ZERO && presc == PRE_ZERO)
		else $error("source change did not clear");

	// a new divider code restarts both counters
	div_clear_a: assert property (
		wr_ctrl && wr_div != divider_select |=>
		count_value == BYTE_ZERO && presc == PRE_ZERO)
		else $error("divider change did not clear");

	// debug holds both counters; writes are excluded since they still act
	debug_freeze_a: assert property (
		debug_active_in && !wr_in |=>
		$stable(count_value) && $stable(presc))
		else $error("counting during debug");

	// reference sources are gone in deep stop, so no tick may come
	deep_stall_a: assert property (
		deep_stop_mode_in && source_select != PMC_SRC_LPO |-> !tick)
		else $error("reference source ran in deep stop");

	// divider code zero means the prescaler is off
	div_off_a: assert property (
		divider_select == DIV_RESET |-> !tick)
		else $error("prescaler ran while off");

	// a write-one clear drops the flag, then the interrupt a cycle later
	flag_clear_a: assert property (
		wr_ctrl && wr_data_in[FLAG_BIT] && !(tick && match) |=>
		!match_flag ##1 !match_irq_out)
		else $error("write one did not clear flag");

	// an enabled flag raises the interrupt one cycle later
	irq_gate_a: assert property (
		match_flag && match_irq_enable |=> match_irq_out)
		else $error("interrupt not raised");

	// with the enable low the interrupt stays quiet, polling only
	irq_mask_a: assert property (
		!match_irq_enable |=> !match_irq_out)
		else $error("interrupt raised while disabled");

	// the count read returns the count of the strobe cycle
	count_read_a: assert property (
		rd_in && addr_in == OFS_CURRENT_COUNT |=>
		rd_data_out == $past(count_value))
		else $error("count read wrong");

	// the control read returns the source field where it belongs
	ctrl_read_a: assert property (
		rd_in && addr_in == OFS_CONTROL_STATUS |=>
		rd_data_out[SEL_HI:SEL_LO] == $past(source_select))
		else $error("source field read wrong");

endmodule

`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the periodic modulo counter
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import pmc_pkg::*;

	// clock, reset and register port
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wr_data_in = 8'h00;
	logic [7:0] rd_data_out;
	// source clocks (bit 0 low power, 1 external, 2 internal) and modes
	logic [2:0] src = 3'h0;
	logic deep = 1'b0;
	logic dbg = 1'b0;
	logic irq;
	// counters and bench-side model of the block
	int fails = 0;
	int check_count = 0;
	int pre = 0;
	int ratio = 0;
	logic [7:0] cnt = 8'h00;
	logic [7:0] lim = 8'h00;
	logic [7:0] ctl = 8'h00;
	logic flag = 1'b0;
	// short divider codes keep the run small
	logic [3:0] pick [6] = '{4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};

	// 200 MHz clock
	always #2.5 clk_in = ~clk_in;

	pmc_counter dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
		.rd_data_out(rd_data_out), .low_power_osc_clock_in(src[0]),
		.external_ref_clock_in(src[1]), .internal_ref_clock_in(src[2]),
		.deep_stop_mode_in(deep), .debug_active_in(dbg),
		.match_irq_out(irq));

	////////////////////////////////////////////////////////////////////////
	// expected divide ratio, written out apart from the design's helper
	function automatic int ratio_of(input logic [3:0] c, input logic b);
		int bin [16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16,
			100, 500, 1000};
		int dec [16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
			1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
		return b ? dec[c] : bin[c];
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rd_data_out;
	endtask

	// control write; counters clear only when source or divider changes
	task automatic set_ctl(input logic [7:0] v);
		if (v[6:5] != ctl[6:5] || v[3:0] != ctl[3:0]) begin
			pre = 0;
			cnt = 8'h00;
		end
		if (v[7]) flag = 1'b0;
		ctl = {1'b0, v[6:0]};
		ratio = ratio_of(v[3:0], v[5]);
		wr(OFS_CONTROL_STATUS, v);
	endtask

	task automatic set_lim(input logic [7:0] v);
		lim = v;
		pre = 0;
		cnt = 8'h00;
		wr(OFS_MATCH_LIMIT, v);
	endtask

	// slow source pulses, well under a quarter of the system clock
	task automatic edges(input int n, input bit go);
		int i;
		int k;
		// only the selected source is pulsed, and only once chosen
		k = ctl[6] ? 2 : (ctl[5] ? 1 : 0);
		for (i = 0; i < n; i++) begin
			@(posedge clk_in);
			src[k] <= 1'b1;
			repeat (4) @(posedge clk_in);
			src[k] <= 1'b0;
			repeat (4) @(posedge clk_in);
			if (go && ratio != 0 && ++pre == ratio) begin
				pre = 0;
				if (cnt == lim) begin
					cnt = 8'h00;
					flag = 1'b1;
				end else begin
					cnt++;
				end
			end
		end
	endtask

	task automatic check_all;
		logic [7:0] d;
		rd(OFS_CURRENT_COUNT, d);
		chk(d, cnt);
		rd(OFS_CONTROL_STATUS, d);
		chk(d, {flag, ctl[6:0]});
		chk({7'h00, irq}, {7'h00, flag & ctl[4]});
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog: a hang counts as a mismatch
	initial begin
		#450000;
		fails++;
		end_of_test;
	end

	initial begin
		logic [7:0] d;
		logic [1:0] s;
		logic [3:0] c;
		int i;
		int n;
		void'($urandom(95563));
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		// reset values, unmapped offset, read-only count, limit readback
		for (i = 0; i < 4; i++) begin
			rd(i[1:0], d);
			chk(d, 8'h00);
		end
		wr(OFS_CURRENT_COUNT, 8'hFF);
		rd(OFS_CURRENT_COUNT, d);
		chk(d, 8'h00);
		set_lim(8'hA5);
		rd(OFS_MATCH_LIMIT, d);
		chk(d, 8'hA5);
		$display("test registers done");
		// each source code in turn, code 8 for the 01/11 sources and random dividers otherwise, random limits and pulse counts
		for (i = 0; i < 8; i++) begin
			s = i[1:0];
			c = s[0] ? 4'h8 : pick[$urandom_range(0, 5)];
			set_ctl({1'b1, s, 1'($urandom_range(0, 1)), c});
			set_lim(8'($urandom_range(0, 3)));
			n = s[0] ? 1000 + $urandom_range(0, 3) :
				ratio * $urandom_range(1, 6) + $urandom_range(0, ratio - 1);
			edges(n, 1'b1);
			check_all;
		end
		$display("test sweep done");
		// zero limit flags every tick; write 0 keeps flag, write 1 clears
		set_ctl(8'h18);
		set_lim(8'h00);
		edges(2, 1'b1);
		check_all;
		set_ctl(8'h18);
		check_all;
		set_ctl(8'h98);
		check_all;
		$display("test flag done");
		// divider, source and limit writes clear the counters
		set_lim(8'h09);
		edges(3, 1'b1);
		set_ctl(8'h19);
		check_all;
		edges(2, 1'b1);
		set_ctl(8'h59);
		check_all;
		edges(4, 1'b1);
		set_lim(8'h09);
		check_all;
		$display("test clears done");
		// debug freeze, deep stop stall, divider off
		edges(2, 1'b1);
		dbg <= 1'b1;
		edges(3, 1'b0);
		dbg <= 1'b0;
		edges(2, 1'b1);
		check_all;
		deep <= 1'b1;
		set_ctl(8'h58);
		edges(3, 1'b0);
		check_all;
		set_ctl(8'h08);
		edges(3, 1'b1);
		check_all;
		deep <= 1'b0;
		set_ctl(8'h00);
		edges(3, 1'b0);
		check_all;
		$display("test modes done");
		end_of_test;
	end
endmodule

`default_nettype wire
